/* branch_eval_map.vh */
// constants for the conditional branch evaluator
// assumes inclusion by bare name from the design file
`ifndef BRANCH_EVAL_MAP_VH
`define BRANCH_EVAL_MAP_VH

// =====================================================================
// branch condition select codes (one per instruction)
`define COND_SAME_OR_HIGHER 3'h0
`define COND_LOWER          3'h1
`define COND_MINUS          3'h2
`define COND_PLUS           3'h3
`define COND_SIGNED_GE      3'h4

// =====================================================================
// widths and reset values
`define PC_WIDTH      16
`define OFFSET_WIDTH  7
`define PC_RESET      16'h0000

// =====================================================================
// cycle counts: not taken finishes in one cycle, taken in two
`define CYCLES_NOT_TAKEN 1
`define CYCLES_TAKEN     2

`endif

/* cbe_chk.sv */
// checker for the branch evaluator
// assumes binding onto the evaluator, whose ports it picks up by name
`timescale 1ns/1ps
`default_nettype none
module cbe_chk (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        start,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        taken,
	input wire logic        pc_load,
	input wire logic        flag_carry,
	input wire logic        flag_negative,
	input wire logic        flag_overflow,
	input wire logic        flag_carry_out,
	input wire logic        flag_negative_out,
	input wire logic        flag_overflow_out,
	input wire logic [2:0]  cond_sel,
	input wire logic [6:0]  offset,
	input wire logic [15:0] program_counter,
	input wire logic [15:0] pc_next
);
	// =================================================================
	// helper terms
	logic [15:0] tgt;
	wire         go        = start & !busy;
	wire [4:0]   cv        = {!(flag_negative ^ flag_overflow), !flag_negative, flag_negative,
		flag_carry, !flag_carry};
	wire         cnd       = cond_sel < 3'h5 && cv[cond_sel];
	wire [2:0]   flags_in  = {flag_carry, flag_negative, flag_overflow};
	wire [2:0]   flags_out = {flag_carry_out, flag_negative_out, flag_overflow_out};
	wire         jump_ok   = pc_load && done && pc_next == tgt;
	// target kept from the start edge, busy guards it
	always_ff @(posedge clk) if (go) tgt <= program_counter + {{9{offset[6]}}, offset} + 16'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// =================================================================
	// properties
	same_higher_a: assert property (go && cond_sel == 3'h0 |=> taken == $past(cv[0]))
		else $error("same-or-higher branch outcome wrong");
	lower_branch_a: assert property (go && cond_sel == 3'h1 |=> taken == $past(cv[1]))
		else $error("lower branch outcome wrong");
	minus_branch_a: assert property (go && cond_sel == 3'h2 |=> taken == $past(cv[2]))
		else $error("minus branch outcome wrong");
	plus_branch_a: assert property (go && cond_sel == 3'h3 |=> taken == $past(cv[3]))
		else $error("plus branch outcome wrong");
	signed_ge_a: assert property (go && cond_sel == 3'h4 |=> taken == $past(cv[4]))
		else $error("signed greater-or-equal branch outcome wrong");
	jump_target_a: assert property (go && cnd |=> busy ##1 jump_ok)
		else $error("taken branch did not load the target");
	fall_through_a: assert property (go && !cnd |=> done && !busy && !pc_load)
		else $error("branch not taken did not finish in one cycle");
	flags_kept_a: assert property ($past(resetn) |-> flags_out == $past(flags_in))
		else $error("flag outputs differ from the flags of the previous cycle");
endmodule // cbe_chk
bind conditional_branch_eval cbe_chk u_chk (.*);
`default_nettype wire

/* conditional_branch_eval.v */
// conditional relative branch evaluator for an 8-bit core
// assumes condition, offset, counter and flags are valid in the cycle start is high
// all outputs are registered, so the core sees each result one edge later
// Functional notes
// RL1: same-or-higher branch is taken only when carry is 0, else falls through.
// RL2: lower branch is taken only when carry is 1, else falls through.
// RL3: minus branch is taken only when negative is 1, else falls through.
// RL4: plus branch is taken only when negative is 0, else falls through.
// RL5: signed greater-or-equal branch is taken only when negative xor overflow is 0.
// RL6: a taken branch loads program counter plus offset plus 1, two cycles after start.
// RL7: status flags are never altered by any of these branches.
`timescale 1ns/1ps
`default_nettype none
`include "branch_eval_map.vh"

module conditional_branch_eval #(
	parameter PC_W  = `PC_WIDTH,
	parameter OFF_W = `OFFSET_WIDTH
) (
	input  wire             clk,
	input  wire             resetn,
	input  wire             start,
	input  wire [2:0]       cond_sel,
	input  wire [OFF_W-1:0] offset,
	input  wire [PC_W-1:0]  program_counter,
	input  wire             flag_carry,
	input  wire             flag_negative,
	input  wire             flag_overflow,
	output reg              busy,
	output reg              done,
	output reg              taken,
	output reg              pc_load,
	output reg  [PC_W-1:0]  pc_next,
	output reg              flag_carry_out,
	output reg              flag_negative_out,
	output reg              flag_overflow_out
);

	// =================================================================
	// states, one-hot
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_JUMP = 2'b10;

	// =================================================================
	// condition table
	localparam NUM_COND = 5;
	localparam CODE_W   = 3;

	// select code of each entry, entry 0 in the low bits
	localparam [CODE_W*NUM_COND-1:0] COND_CODES = {
		`COND_SIGNED_GE,
		`COND_PLUS,
		`COND_MINUS,
		`COND_LOWER,
		`COND_SAME_OR_HIGHER
	};

	// level of the tested flag that lets each entry branch
	localparam [NUM_COND-1:0] WANT_LEVEL = {
		1'b0, // RL5
		1'b0, // RL4
		1'b1, // RL3
		1'b1, // RL2
		1'b0  // RL1
	};

	// reset value of the address registers
	localparam [PC_W-1:0] PC_INIT = `PC_RESET;

	// =================================================================
	// declarations
	reg  [1:0]          state;
	reg  [1:0]          next_state;
	reg  [PC_W-1:0]     target;
	reg  [PC_W-1:0]     next_target;
	reg                 next_busy;
	reg                 next_done;
	reg                 next_taken;
	reg                 next_pc_load;
	reg  [PC_W-1:0]     next_pc_next;
	wire                idle;
	wire                accept;
	wire                cond_true;
	wire [NUM_COND-1:0] flag_test;
	wire [NUM_COND-1:0] cond_pick;
	wire [NUM_COND-1:0] cond_hit;
	wire [PC_W-1:0]     offset_ext;
	wire [PC_W-1:0]     one_ext;
	wire [PC_W-1:0]     sum_target;

	// =================================================================
	// flag looked at by each entry
	assign flag_test[0] = flag_carry;                    // RL1
	assign flag_test[1] = flag_carry;                    // RL2
	assign flag_test[2] = flag_negative;                 // RL3
	assign flag_test[3] = flag_negative;                 // RL4
	assign flag_test[4] = flag_negative ^ flag_overflow; // RL5

	// =================================================================
	// one entry per branch kind
	// codes outside the table pick no entry, so they never branch
	genvar gi;
	generate
		for (gi = 0; gi < NUM_COND; gi = gi + 1) begin : g_cond
			assign cond_pick[gi] = (cond_sel == COND_CODES[CODE_W*gi +: CODE_W]);
			assign cond_hit[gi]  = cond_pick[gi] & (flag_test[gi] == WANT_LEVEL[gi]);
		end
	endgenerate

	assign cond_true = |cond_hit;

	// =================================================================
	// target address
	// the sum wraps at the top of the address space, as the counter does
	assign offset_ext = {{(PC_W-OFF_W){offset[OFF_W-1]}}, offset};
	assign one_ext    = {{(PC_W-1){1'b0}}, 1'b1};
	assign sum_target = program_counter + offset_ext + one_ext; // RL6

	// =================================================================
	// request acceptance
	// a start during the jump cycle is dropped, not queued
	assign idle   = (state == ST_IDLE);
	assign accept = start & idle;

	// =================================================================
	// control: a taken branch costs one extra cycle
	always @* begin
		next_state   = state;
		next_busy    = busy;
		next_done    = 1'b0;
		next_pc_load = 1'b0;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					if (cond_true) begin
						next_busy  = 1'b1;
						next_state = ST_JUMP;
					end else begin
						// not taken ends here and leaves the counter alone
						next_done = 1'b1;
					end
				end
			end
			ST_JUMP: begin
				next_pc_load = 1'b1; // RL6
				next_done    = 1'b1;
				next_busy    = 1'b0;
				next_state   = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
				next_busy  = 1'b0;
			end
		endcase
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state   <= ST_IDLE;
			busy    <= 1'b0;
			done    <= 1'b0;
			pc_load <= 1'b0;
		end else begin
			state   <= next_state;
			busy    <= next_busy;
			done    <= next_done;
			pc_load <= next_pc_load;
		end
	end

	// =================================================================
	// outcome of the last evaluation, kept until the next start
	always @* begin
		next_taken = taken;
		if (accept) begin
			next_taken = cond_true;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			taken <= 1'b0;
		end else begin
			taken <= next_taken;
		end
	end

	// =================================================================
	// address: target captured at the start edge, loaded one cycle later
	// the counter input may move meanwhile, the held target is what loads
	always @* begin
		next_target  = target;
		next_pc_next = pc_next;
		if (accept && cond_true) begin
			next_target = sum_target; // RL6
		end
		if (state == ST_JUMP) begin
			next_pc_next = target; // RL6
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			target  <= PC_INIT;
			pc_next <= PC_INIT;
		end else begin
			target  <= next_target;
			pc_next <= next_pc_next;
		end
	end

	// =================================================================
	// flags pass through registered and untouched by any branch
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag_carry_out    <= 1'b0;
			flag_negative_out <= 1'b0;
			flag_overflow_out <= 1'b0;
		end else begin
			flag_carry_out    <= flag_carry;    // RL7
			flag_negative_out <= flag_negative; // RL7
			flag_overflow_out <= flag_overflow; // RL7
		end
	end

endmodule // conditional_branch_eval
`default_nettype wire

/* conditional_branch_eval_tb.sv */
// self-checking bench for the branch evaluator
// assumes the checker binds itself
`timescale 1ns/1ps
`default_nettype none
module conditional_branch_eval_tb;
	logic        clk = 0, resetn = 0, start = 0, c = 0, n = 0, v = 0;
	logic        busy, done, taken, pc_load, fc, fn, fv;
	logic [2:0]  sel = 3'h0;
	logic [6:0]  k = 7'h00;
	logic [15:0] pc = 16'h0000, pn;
	int          err_count = 0, checks_done = 0;
	always #12.5 clk = ~clk;
	conditional_branch_eval u_dut (.clk(clk), .resetn(resetn), .start(start), .cond_sel(sel),
		.offset(k), .program_counter(pc), .flag_carry(c), .flag_negative(n), .flag_overflow(v),
		.busy(busy), .done(done), .taken(taken), .pc_load(pc_load), .pc_next(pn),
		.flag_carry_out(fc), .flag_negative_out(fn), .flag_overflow_out(fv));
	task ck(input string nm, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task run(input logic [2:0] s, f, input logic [15:0] p, input logic [6:0] o);
		logic e;
		e = s == 3'h0 ? !f[2] : s == 3'h1 ? f[2] : s == 3'h2 ? f[1] : s == 3'h3 ? !f[1] :
			s == 3'h4 && !(f[1] ^ f[0]);
		{sel, c, n, v, pc, k, start} = {s, f, p, o, 1'b1};
		@(posedge clk) #2 start = 0;
		{c, n, v} = ~f;
		ck("taken", e, taken);
		ck("flags", f, {fc, fn, fv});
		ck("busy", e, busy);
		ck("done early", !e, done);
		@(posedge clk) #2 ck("done", e, done);
		ck("load", e, pc_load);
		if (e) ck("pc_next", p + {{9{o[6]}}, o} + 16'h1, pn);
	endtask
	task t_unsigned;
		for (int i = 0; i < 2; i++) begin
			run(3'h0, {i[0], 2'h0}, 16'h1000, 7'h05);
			run(3'h1, {i[0], 2'h3}, 16'h1000, 7'h05);
		end
	endtask
	task t_sign;
		for (int i = 0; i < 2; i++) begin
			run(3'h2, {1'b0, i[0], 1'b0}, 16'h2000, 7'h7f);
			run(3'h3, {1'b1, i[0], 1'b1}, 16'h2000, 7'h7f);
		end
	endtask
	task t_signed_ge;
		// wraps past the top of the address space
		for (int i = 0; i < 4; i++) run(3'h4, {1'b0, i[1:0]}, 16'hfffe, 7'h01);
	endtask
	task t_offsets;
		run(3'h4, 3'h0, 16'h0000, 7'h40);
		run(3'h0, 3'h0, 16'h0040, 7'h3f);
		run(3'h7, 3'h0, 16'h0040, 7'h3f);
	endtask
	task t_refused;
		// a second start during the jump cycle must be dropped
		{sel, c, n, v, pc, k, start} = {3'h0, 3'h0, 16'h3000, 7'h02, 1'b1};
		@(posedge clk) #2 pc = 16'h4000;
		@(posedge clk) #2 start = 0;
		ck("refused pc_next", 16'h3003, pn);
		ck("refused load", 16'h0001, pc_load);
		@(posedge clk) #2 ck("refused done", 16'h0000, done);
		ck("refused busy", 16'h0000, busy);
	endtask
	task final_report;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#2 resetn = 1;
		t_unsigned();
		t_sign();
		t_signed_ge();
		t_offsets();
		t_refused();
		final_report();
	end
endmodule // conditional_branch_eval_tb
`default_nettype wire
